// *** hw/fts_compare.sv ***
/*
  Registered threshold comparators: for each threshold, whether the
  sample is at or above it and strictly above it. One cycle latency.
*/
`timescale 1ns/1ps
`default_nettype none

module fts_compare #(
  parameter int unsigned N     = 3,
  parameter int unsigned WIDTH = 10
) (
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  input  wire logic [WIDTH-1:0]       sample,
  input  wire logic [N-1:0][WIDTH-1:0] limit,
  output logic [N-1:0]                at_or_above,
  output logic [N-1:0]                above
);

  typedef struct packed {
    logic [N-1:0] ge;
    logic [N-1:0] gt;
  } fts_cmp_t;

  fts_cmp_t     cmp_reg;
  fts_cmp_t     cmp_next;
  logic [N-1:0] ge_w;
  logic [N-1:0] gt_w;

  for (genvar i = 0; i < N; i++) begin : g_cmp
    assign ge_w[i] = (sample >= limit[i]);
    assign gt_w[i] = (sample > limit[i]);
  end

  always_comb begin
    cmp_next    = cmp_reg;
    cmp_next.ge = ge_w;
    cmp_next.gt = gt_w;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cmp_reg <= '0;
    end else begin
      cmp_reg <= cmp_next;
    end
  end

  assign at_or_above = cmp_reg.ge;
  assign above       = cmp_reg.gt;

endmodule // fts_compare

`default_nettype wire

// *** hw/fts_supervisor.sv ***
/*
  Fuser temperature supervisor: register port, warm-up and regulation
  sequence, fault detection with latched display code.
  Assumes a synchronous temperature sample with a valid strobe, and an
  external relay that opens while overheat_relay_cut is high.
*/
`timescale 1ns/1ps
`default_nettype none

module fts_supervisor
  import fts_pkg::*;
#(
  parameter logic [fts_pkg::CNT_W-1:0]  WARMUP_LIMIT = fts_pkg::WARMUP_CYCLES,
  parameter logic [fts_pkg::CNT_W-1:0]  HEATER_LIMIT =
    fts_pkg::HEATER_ON_CYCLES,
  parameter logic [fts_pkg::TEMP_W-1:0] SETPOINT_DEF = fts_pkg::SETPOINT_RST,
  parameter logic [fts_pkg::TEMP_W-1:0] WARMUP_DEF   = fts_pkg::WARMUP_RST,
  parameter logic [fts_pkg::TEMP_W-1:0] OVERHEAT_DEF = fts_pkg::OVERHEAT_RST
) (
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  input  wire logic [fts_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [fts_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_write,
  input  wire logic                        reg_read,
  output logic [fts_pkg::DATA_W-1:0]       reg_rdata,
  input  wire logic [fts_pkg::TEMP_W-1:0]  temp_sample,
  input  wire logic                        temp_valid,
  input  wire logic                        thermistor_shutdown_flag,
  output logic                             heater_drive_low,
  output logic                             overheat_relay_cut,
  output logic [2:0]                       fault_code,
  output logic                             printer_halt
);

  import fts_pkg::*;

  localparam int unsigned IDX_SET  = 0;
  localparam int unsigned IDX_WARM = 1;
  localparam int unsigned IDX_HOT  = 2;

  typedef struct packed {
    fts_state_t              state;
    fts_code_t               code;
    logic                    heater_on;
    logic                    relay_cut;
    logic                    halt;
    logic                    sampled;
    logic [TEMP_W-1:0]       temp;
    logic                    heat_en;
    logic [TEMP_W-1:0]       setpoint;
    logic [TEMP_W-1:0]       warmup;
    logic [TEMP_W-1:0]       overheat;
    logic [DATA_W-1:0]       rdata;
  } fts_sup_t;

  fts_sup_t            sup_reg;
  fts_sup_t            sup_next;
  logic [2:0]          cmp_ge;
  logic [2:0]          cmp_gt;
  logic [2:0][TEMP_W-1:0] limits;
  logic                warmup_expired;
  logic                heater_expired;
  logic [DATA_W-1:0]   status_word;
  logic                wr_heat;

  assign limits[IDX_SET]  = sup_reg.setpoint;
  assign limits[IDX_WARM] = sup_reg.warmup;
  assign limits[IDX_HOT]  = sup_reg.overheat;

  // Thresholds are compared against the held sample, never the raw input
  fts_compare #(
    .N     (3),
    .WIDTH (TEMP_W)
  ) u_compare (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .sample      (sup_reg.temp),
    .limit       (limits),
    .at_or_above (cmp_ge),
    .above       (cmp_gt)
  );

  fts_timer #(
    .CNT_W (CNT_W),
    .LIMIT (WARMUP_LIMIT)
  ) u_warmup_timer (
    .clk_sys (clk_sys),
    .reset   (reset),
    .run     (sup_reg.state == FTS_ST_WARMUP),
    .expired (warmup_expired)
  );

  // Counts only continuous drive; any off cycle restarts it
  fts_timer #(
    .CNT_W (CNT_W),
    .LIMIT (HEATER_LIMIT)
  ) u_heater_timer (
    .clk_sys (clk_sys),
    .reset   (reset),
    .run     (sup_reg.heater_on),
    .expired (heater_expired)
  );

  always_comb begin
    status_word = '0;
    status_word[ST_CODE_LSB +: 3]  = sup_reg.code;
    status_word[ST_STATE_LSB +: 4] = sup_reg.state;
    status_word[ST_HEATER_BIT]     = sup_reg.heater_on;
    status_word[ST_RELAY_BIT]      = sup_reg.relay_cut;
    status_word[ST_HALT_BIT]       = sup_reg.halt;
    status_word[ST_SAMPLED_BIT]    = sup_reg.sampled;
  end

  assign wr_heat = reg_wdata[CTRL_HEAT_EN_BIT];

  always_comb begin
    sup_next       = sup_reg;
    sup_next.rdata = '0;

    // Register writes
    if (reg_write) begin
      unique case (reg_addr)
        OFS_CTRL: begin
          sup_next.heat_en = wr_heat;
        end
        OFS_SETPOINT: begin
          sup_next.setpoint = reg_wdata[TEMP_W-1:0];
        end
        OFS_WARMUP: begin
          sup_next.warmup = reg_wdata[TEMP_W-1:0];
        end
        OFS_OVERHEAT: begin
          sup_next.overheat = reg_wdata[TEMP_W-1:0];
        end
        default: begin
          sup_next.heat_en = sup_reg.heat_en;
        end
      endcase
    end

    // Register reads answer in the next cycle only
    if (reg_read) begin
      unique case (reg_addr)
        OFS_CTRL: begin
          sup_next.rdata = DATA_W'(sup_reg.heat_en);
        end
        OFS_SETPOINT: begin
          sup_next.rdata = DATA_W'(sup_reg.setpoint);
        end
        OFS_WARMUP: begin
          sup_next.rdata = DATA_W'(sup_reg.warmup);
        end
        OFS_OVERHEAT: begin
          sup_next.rdata = DATA_W'(sup_reg.overheat);
        end
        OFS_STATUS: begin
          sup_next.rdata = status_word;
        end
        OFS_TEMP: begin
          sup_next.rdata = DATA_W'(sup_reg.temp);
        end
        default: begin
          sup_next.rdata = '0;
        end
      endcase
    end

    // Take each digitised thermistor sample
    if (temp_valid) begin
      sup_next.temp    = temp_sample;
      sup_next.sampled = 1'b1;
    end

    // Sequencing and regulation
    unique case (sup_reg.state)
      FTS_ST_IDLE: begin
        sup_next.heater_on = 1'b0;
        if (sup_reg.heat_en && sup_reg.sampled) begin
          sup_next.state = FTS_ST_WARMUP;
        end
      end
      FTS_ST_WARMUP, FTS_ST_READY: begin
        // Hysteresis band is the single code equal to the setpoint
        if (!cmp_ge[IDX_SET]) begin
          sup_next.heater_on = 1'b1;
        end else if (cmp_gt[IDX_SET]) begin
          sup_next.heater_on = 1'b0;
        end
        if (sup_reg.state == FTS_ST_WARMUP && cmp_ge[IDX_WARM]) begin
          sup_next.state = FTS_ST_READY;
        end
        if (!sup_reg.heat_en) begin
          sup_next.state     = FTS_ST_IDLE;
          sup_next.heater_on = 1'b0;
        end
      end
      FTS_ST_FAULT: begin
        sup_next.heater_on = 1'b0;
      end
      default: begin
        sup_next.state     = FTS_ST_FAULT;
        sup_next.heater_on = 1'b0;
      end
    endcase

    // Overheat opens the relay at once, in any state
    if (sup_reg.sampled && cmp_ge[IDX_HOT]) begin
      sup_next.relay_cut = 1'b1;
    end

    // Fault detection, highest priority last so it wins
    if (sup_reg.state != FTS_ST_FAULT) begin
      if (warmup_expired) begin
        sup_next.code = FTS_CODE_WARMUP;
      end
      if (heater_expired) begin
        sup_next.code = FTS_CODE_HEATER;
      end
      if (sup_reg.relay_cut) begin
        sup_next.code = FTS_CODE_OVERHEAT;
      end
      if (thermistor_shutdown_flag) begin
        sup_next.code = FTS_CODE_THERMISTOR;
      end
      if (warmup_expired || heater_expired || sup_reg.relay_cut ||
          thermistor_shutdown_flag) begin
        sup_next.state     = FTS_ST_FAULT;
        sup_next.heater_on = 1'b0;
        sup_next.halt      = 1'b1;
      end
    end
  end

  // Faults are cleared only by reset, so a tripped fuser never reheats
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sup_reg          <= '0;
      sup_reg.state    <= FTS_ST_IDLE;
      sup_reg.code     <= FTS_CODE_NONE;
      sup_reg.heat_en  <= CTRL_HEAT_EN_RST;
      sup_reg.setpoint <= SETPOINT_DEF;
      sup_reg.warmup   <= WARMUP_DEF;
      sup_reg.overheat <= OVERHEAT_DEF;
    end else begin
      sup_reg <= sup_next;
    end
  end

  assign heater_drive_low   = ~sup_reg.heater_on;
  assign overheat_relay_cut = sup_reg.relay_cut;
  assign fault_code         = sup_reg.code;
  assign printer_halt       = sup_reg.halt;
  assign reg_rdata          = sup_reg.rdata;

endmodule // fts_supervisor

`default_nettype wire

// *** hw/fts_timer.sv ***
/*
  Watchdog counter: counts while run is high and flags expiry after
  LIMIT cycles. Assumes run drops to restart it.
*/
`timescale 1ns/1ps
`default_nettype none

module fts_timer #(
  parameter int unsigned             CNT_W = 40,
  parameter logic [CNT_W-1:0]        LIMIT = 40'h0000000010
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic run,
  output logic      expired
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             expired;
  } fts_tmr_t;

  fts_tmr_t tmr_reg;
  fts_tmr_t tmr_next;

  always_comb begin
    tmr_next = tmr_reg;
    if (!run) begin
      tmr_next.cnt     = '0;
      tmr_next.expired = 1'b0;
    end else if (tmr_reg.cnt >= LIMIT - 1'b1) begin
      tmr_next.expired = 1'b1;
    end else begin
      tmr_next.cnt = tmr_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tmr_reg <= '0;
    end else begin
      tmr_reg <= tmr_next;
    end
  end

  assign expired = tmr_reg.expired;

endmodule // fts_timer

`default_nettype wire

// *** pkg/fts_pkg.sv ***
/*
  Constants, state codes and register map of the fuser temperature
  supervisor. Assumes a single 250 MHz system clock and a synchronous
  reset. Temperature samples and thresholds share one code scale.
*/
`default_nettype none

package fts_pkg;

  localparam int unsigned TEMP_W = 10;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W  = 40;

  // Thresholds in sample code units, one code per degree
  localparam logic [TEMP_W-1:0] SETPOINT_RST = 10'h092;
  localparam logic [TEMP_W-1:0] OVERHEAT_RST = 10'h0B9;
  localparam logic [TEMP_W-1:0] WARMUP_RST   = 10'h08C;

  // Timing: time in its own unit, then cycles at the clock rate
  localparam longint unsigned CLK_KHZ             = 64'h3D090;
  localparam longint unsigned WARMUP_TIMEOUT_MS   = 64'hEA60;
  localparam longint unsigned HEATER_ON_TIMEOUT_MS = 64'h1D4C0;
  localparam logic [CNT_W-1:0] WARMUP_CYCLES =
    CNT_W'(WARMUP_TIMEOUT_MS * CLK_KHZ);
  localparam logic [CNT_W-1:0] HEATER_ON_CYCLES =
    CNT_W'(HEATER_ON_TIMEOUT_MS * CLK_KHZ);

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SETPOINT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_WARMUP   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_OVERHEAT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_TEMP     = 8'h14;

  // Field positions
  localparam int unsigned CTRL_HEAT_EN_BIT = 0;
  localparam int unsigned ST_CODE_LSB      = 0;
  localparam int unsigned ST_STATE_LSB     = 4;
  localparam int unsigned ST_HEATER_BIT    = 8;
  localparam int unsigned ST_RELAY_BIT     = 9;
  localparam int unsigned ST_HALT_BIT      = 10;
  localparam int unsigned ST_SAMPLED_BIT   = 11;
  localparam logic        CTRL_HEAT_EN_RST = 1'b0;

  typedef enum logic [2:0] {
    FTS_CODE_NONE       = 3'h0,
    FTS_CODE_THERMISTOR = 3'h1,
    FTS_CODE_WARMUP     = 3'h2,
    FTS_CODE_HEATER     = 3'h3,
    FTS_CODE_OVERHEAT   = 3'h4
  } fts_code_t;

  typedef enum logic [3:0] {
    FTS_ST_IDLE   = 4'h1,
    FTS_ST_WARMUP = 4'h2,
    FTS_ST_READY  = 4'h4,
    FTS_ST_FAULT  = 4'h8
  } fts_state_t;

endpackage

`default_nettype wire

// *** tb/fts_fuser_model.sv ***
/*
  Fuser model: roller heats one code per sample while the heater is on
  and the relay closed, else cools. Assumes bench drives load and trip.
*/
`timescale 1ns/1ps
`default_nettype none
module fts_fuser_model #(
  parameter int unsigned DIV = 4
) (
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  input  wire logic                       heater_drive_low,
  input  wire logic                       overheat_relay_cut,
  input  wire logic                       load,
  input  wire logic [fts_pkg::TEMP_W-1:0] load_val,
  input  wire logic                       trip,
  output logic [fts_pkg::TEMP_W-1:0]      temp_sample,
  output logic                            temp_valid,
  output logic                            thermistor_shutdown_flag,
  output logic [fts_pkg::TEMP_W-1:0]      temp_now
);
  import fts_pkg::*;
  int unsigned div_q;
  assign thermistor_shutdown_flag = trip;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      div_q <= 0;
      temp_now <= 10'h014;
      temp_valid <= 1'b0;
      temp_sample <= 10'h3FF;
    end else begin
      div_q <= (div_q == DIV - 1) ? 0 : div_q + 1;
      temp_valid <= (div_q == 0);
      // Between samples the bus toggles so a stale read cannot pass
      temp_sample <= (div_q == 0) ? temp_now : ~temp_sample;
      if (load)
        temp_now <= load_val;
      else if (div_q == 0 && !heater_drive_low && !overheat_relay_cut)
        temp_now <= temp_now + 10'h001;
      else if (div_q == 0 && temp_now > 10'h014)
        temp_now <= temp_now - 10'h001;
    end
  end
endmodule // fts_fuser_model
`default_nettype wire

// *** tb/fts_supervisor_props.sv ***
/*
  Concurrent checks on the supervisor's top ports.
  Assumes it is bound into fts_supervisor; one clock, sync reset.
*/
`timescale 1ns/1ps
`default_nettype none
module fts_supervisor_props #(
  parameter logic [fts_pkg::CNT_W-1:0] HEATER_LIMIT = 40'h12C
) (
  input wire logic                       clk_sys,
  input wire logic                       reset,
  input wire logic                       reg_read,
  input wire logic [fts_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [fts_pkg::TEMP_W-1:0] temp_sample,
  input wire logic                       temp_valid,
  input wire logic                       thermistor_shutdown_flag,
  input wire logic                       heater_drive_low,
  input wire logic                       overheat_relay_cut,
  input wire logic [2:0]                 fault_code,
  input wire logic                       printer_halt
);
  import fts_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Unbroken heater-on run; a long count is cheaper here than in a repeat
  logic [CNT_W-1:0] on_cnt;
  always_ff @(posedge clk_sys) begin
    if (reset || heater_drive_low)
      on_cnt <= '0;
    else
      on_cnt <= on_cnt + 40'h1;
  end
  a_therm_fault: assert property (
    thermistor_shutdown_flag && fault_code == 3'h0 |-> ##[1:2]
    (fault_code == 3'h1 && printer_halt && heater_drive_low))
    else $error("thermistor flag did not raise code 1");
  a_fault_heat_off: assert property (
    fault_code != 3'h0 |=> heater_drive_low)
    else $error("heater driven while faulted");
  a_fault_held: assert property (
    fault_code != 3'h0 |=> $stable(fault_code) && printer_halt)
    else $error("fault code not held");
  a_halt_code: assert property (
    printer_halt |-> fault_code != 3'h0)
    else $error("halt without code");
  a_cut_code: assert property (
    $rose(overheat_relay_cut) && fault_code == 3'h0 &&
    !thermistor_shutdown_flag && !$past(thermistor_shutdown_flag)
    |=> fault_code == 3'h4 && printer_halt)
    else $error("relay cut without code 4");
  a_cut_held: assert property (
    overheat_relay_cut |=> overheat_relay_cut)
    else $error("relay cut released");
  a_hot_cuts: assert property (
    temp_valid && temp_sample >= OVERHEAT_RST && fault_code == 3'h0
    |-> ##[1:4] overheat_relay_cut)
    else $error("overheat sample did not cut relay");
  a_stuck_bound: assert property (
    on_cnt <= HEATER_LIMIT + 40'h3)
    else $error("heater on past its limit");
  a_heat_allowed: assert property (
    $fell(heater_drive_low) |-> fault_code == 3'h0 && !overheat_relay_cut)
    else $error("heater turned on while faulted");
  a_rdata_idle: assert property (
    !$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
endmodule // fts_supervisor_props
`default_nettype wire

// *** tb/fts_supervisor_tb.sv ***
/*
  Self-checking bench for the supervisor, one task per scenario.
  Assumes the fuser model beside it and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module fts_supervisor_tb;
  import fts_pkg::*;
  logic              clk_sys = 1'b0;
  logic              reset = 1'b1;
  logic              reg_write = 1'b0;
  logic              reg_read = 1'b0;
  logic              load = 1'b0;
  logic              trip = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [DATA_W-1:0] reg_rdata;
  logic [TEMP_W-1:0] load_val = '0;
  logic [TEMP_W-1:0] temp_sample;
  logic [TEMP_W-1:0] temp_now;
  logic              temp_valid;
  logic              thermistor_shutdown_flag;
  logic              heater_drive_low;
  logic              overheat_relay_cut;
  logic              printer_halt;
  logic [2:0]        fault_code;
  int                fails = 0;
  int                n_compared = 0;
  int                cyc = 0;
  // Short limits keep the run brief
  fts_supervisor #(.WARMUP_LIMIT(40'h0C8), .HEATER_LIMIT(40'h12C)) i_dut (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .temp_sample(temp_sample),
    .temp_valid(temp_valid),
    .thermistor_shutdown_flag(thermistor_shutdown_flag),
    .heater_drive_low(heater_drive_low),
    .overheat_relay_cut(overheat_relay_cut), .fault_code(fault_code),
    .printer_halt(printer_halt));
  fts_fuser_model i_fuser (
    .clk_sys(clk_sys), .reset(reset), .heater_drive_low(heater_drive_low),
    .overheat_relay_cut(overheat_relay_cut), .load(load),
    .load_val(load_val), .trip(trip), .temp_sample(temp_sample),
    .temp_valid(temp_valid),
    .thermistor_shutdown_flag(thermistor_shutdown_flag),
    .temp_now(temp_now));
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic finish_test();
    if (fails == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask
  task automatic do_reset();
    reset <= 1'b1;
    trip <= 1'b0;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
  endtask
  task automatic set_temp(input logic [9:0] v);
    @(posedge clk_sys);
    load <= 1'b1;
    load_val <= v;
    @(posedge clk_sys);
    load <= 1'b0;
  endtask
  // Bounded wait for a fault, then check its timing and that it latches
  task automatic t_fault(input logic [2:0] c, input int lo, hi);
    int i;
    i = 0;
    while (fault_code === 3'h0 && i < hi) begin
      @(posedge clk_sys);
      i++;
    end
    chk("fault_time", 32'h1, 32'(i >= lo && i < hi));
    repeat (2) @(posedge clk_sys);
    chk("fault_code", {29'h0, c}, {29'h0, fault_code});
    chk("printer_halt", 32'h1, {31'h0, printer_halt});
    chk("heater_drive_low", 32'h1, {31'h0, heater_drive_low});
    repeat (50) @(posedge clk_sys);
    chk("code_held", {29'h0, c}, {29'h0, fault_code});
  endtask
  task automatic t_regs();
    logic [7:0]  a [5] = '{OFS_CTRL, OFS_SETPOINT, OFS_WARMUP,
                           OFS_OVERHEAT, 8'h20};
    logic [31:0] e [5] = '{32'h0, 32'(SETPOINT_RST), 32'(WARMUP_RST),
                           32'(OVERHEAT_RST), 32'h0};
    logic [31:0] v;
    for (int k = 0; k < 5; k++) begin
      rd(a[k], v);
      chk("reg_reset", e[k], v);
    end
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    rd(OFS_STATUS, v);
    chk("status_idle", 32'h10, v & 32'hFFFF_F7FF);
    wr(OFS_SETPOINT, 32'hFFFF_F0A0);
    rd(OFS_SETPOINT, v);
    chk("setpoint_rw", 32'h0A0, v);
    wr(OFS_SETPOINT, 32'(SETPOINT_RST));
  endtask
  task automatic t_regulate();
    logic [31:0] v;
    int lo_t, hi_t, tog;
    logic prev;
    lo_t = 1023;
    hi_t = 0;
    tog = 0;
    set_temp(10'h08C);
    wr(OFS_CTRL, 32'h1);
    repeat (100) @(posedge clk_sys);
    prev = heater_drive_low;
    repeat (240) begin
      @(posedge clk_sys);
      if (int'(temp_now) < lo_t) lo_t = int'(temp_now);
      if (int'(temp_now) > hi_t) hi_t = int'(temp_now);
      if (heater_drive_low !== prev) tog++;
      prev = heater_drive_low;
    end
    chk("temp_min", 32'h1, 32'(lo_t >= int'(SETPOINT_RST) - 2));
    chk("temp_max", 32'h1, 32'(hi_t <= int'(SETPOINT_RST) + 2));
    chk("heater_toggles", 32'h1, 32'(tog >= 4));
    rd(OFS_STATUS, v);
    chk("state_ready", 32'h40, v & 32'h0000_00F7);
    rd(OFS_TEMP, v);
    chk("temp_reg", 32'h1, 32'(v >= 32'h08F && v <= 32'h095));
    // Clearing the enable must drop the heater and return to idle
    wr(OFS_CTRL, 32'h0);
    rd(OFS_STATUS, v);
    chk("state_idle", 32'h10, v & 32'h0000_01F7);
    chk("heater_idle", 32'h1, {31'h0, heater_drive_low});
  endtask
  task automatic t_warmup();
    do_reset();
    wr(OFS_CTRL, 32'h1);
    t_fault(3'h2, 190, 215);
  endtask
  task automatic t_stuck();
    do_reset();
    wr(OFS_WARMUP, 32'h0);
    wr(OFS_SETPOINT, 32'h3FF);
    wr(OFS_CTRL, 32'h1);
    t_fault(3'h3, 295, 320);
  endtask
  task automatic t_overheat();
    do_reset();
    set_temp(10'h0BE);
    wr(OFS_CTRL, 32'h1);
    t_fault(3'h4, 0, 20);
    chk("relay_cut", 32'h1, {31'h0, overheat_relay_cut});
  endtask
  task automatic t_thermistor();
    do_reset();
    set_temp(10'h08C);
    wr(OFS_CTRL, 32'h1);
    repeat (20) @(posedge clk_sys);
    trip <= 1'b1;
    @(posedge clk_sys);
    trip <= 1'b0;
    t_fault(3'h1, 0, 4);
  endtask
  initial begin
    do_reset();
    t_regs();
    t_regulate();
    t_warmup();
    t_stuck();
    t_overheat();
    t_thermistor();
    finish_test();
  end
endmodule // fts_supervisor_tb
bind fts_supervisor fts_supervisor_props #(.HEATER_LIMIT(HEATER_LIMIT))
  i_props (
  .clk_sys(clk_sys), .reset(reset), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .temp_sample(temp_sample),
  .temp_valid(temp_valid),
  .thermistor_shutdown_flag(thermistor_shutdown_flag),
  .heater_drive_low(heater_drive_low),
  .overheat_relay_cut(overheat_relay_cut), .fault_code(fault_code),
  .printer_halt(printer_halt));
`default_nettype wire
